// ### src/gcnt_pkg.sv
// Package: register map, field layout, modes and shared types of the gated counter
package gcnt_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CONTROL = 5'h00; // Mode, direction, gate config, software gate
  localparam logic [4:0] OFS_LOAD = 5'h04; // Load value
  localparam logic [4:0] OFS_END = 5'h08; // End value for main direction
  localparam logic [4:0] OFS_COUNT = 5'h0C; // Present count, read only
  localparam logic [4:0] OFS_LATCH = 5'h10; // Latch register, read only
  localparam logic [4:0] OFS_STATUS = 5'h14; // Flags; write 1 in bit 0 clears them

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTL_MODE_LSB = 0; // Two bits of counting mode
  localparam int CTL_DIR_LSB = 2; // Two bits of main direction
  localparam int CTL_HWEN_BIT = 4; // Evaluate hardware gate
  localparam int CTL_STOPFN_BIT = 5; // 1: stop (interrupt) gate function, 0: cancel
  localparam int CTL_SWGATE_BIT = 6; // Software gate bit
  localparam int STS_OVF_BIT = 0; // Overflow flag position
  localparam int STS_UNF_BIT = 1; // Underflow flag position
  localparam int STS_IGATE_BIT = 2; // Internal gate state
  localparam int STS_CLR_BIT = 0; // Status clear request bit on write

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] LOAD_RST = 32'h0000_0000;
  localparam logic [31:0] END_RST = 32'h0000_0000;
  localparam logic [31:0] COUNT_UPPER = 32'h7FFF_FFFF; // 2^31-1
  localparam logic [31:0] COUNT_LOWER = 32'h8000_0000; // -2^31
  localparam logic [31:0] ONE = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CONT = 2'h0, // Count continuously
    MODE_ONCE = 2'h1, // Count once
    MODE_PERIOD = 2'h3 // Count periodically
  } mode_t;

  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_UP = 2'h1,
    DIR_DOWN = 2'h3
  } dir_t;

  // Configuration seen by the counter core
  typedef struct packed {
    logic [31:0] load_value;
    logic [31:0] end_value;
    logic [1:0] mode;
    logic [1:0] dir;
    logic hw_enable;
    logic stop_fn;
    logic software_gate_bit;
  } cfg_t;

  // Encoder and input pins
  typedef struct packed {
    logic count_up;
    logic count_down;
    logic hardware_gate;
    logic latch;
  } pins_t;

  // State reported by the counter core
  typedef struct packed {
    logic [31:0] count;
    logic [31:0] latch_value;
    logic overflow_flag;
    logic underflow_flag;
    logic internal_gate;
  } core_status_t;

endpackage

// ### src/gcnt_core.sv
// Counter core: gate logic, counting modes, flags and latch
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gcnt_core (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Configuration and control
  input wire gcnt_pkg::cfg_t cfg_i,
  input wire logic status_clear_request_i,
  // Pins
  input wire gcnt_pkg::pins_t pins_i,
  // State out
  output gcnt_pkg::core_status_t stat_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] count; // Two's complement count
    logic [31:0] latch_value; // Captured count
    logic ovf; // Sticky overflow
    logic unf; // Sticky underflow
    logic auto_closed; // Gate closed by the counter itself
    logic hw_open; // Hardware gate, edge driven
    logic hw_prev; // Previous gate pin level
    logic sw_prev; // Previous software gate bit
    logic latch_prev; // Previous latch pin level
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  // Derived gate terms
  logic hw_term;
  logic igate;
  logic hw_rise;
  logic sw_rise;
  logic up_pulse;
  logic dn_pulse;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Gate, restarts, counting and flags in one pass; one pulse per cycle at most
  always_comb begin
    next_st = st;
    hw_rise = pins_i.hardware_gate && !st.hw_prev;
    sw_rise = cfg_i.software_gate_bit && !st.sw_prev;
    hw_term = cfg_i.hw_enable ? st.hw_open : 1'b1;
    igate = cfg_i.software_gate_bit && hw_term && !st.auto_closed;
    up_pulse = pins_i.count_up && !pins_i.count_down;
    dn_pulse = pins_i.count_down && !pins_i.count_up;
    next_st.hw_prev = pins_i.hardware_gate;
    next_st.sw_prev = cfg_i.software_gate_bit;
    next_st.latch_prev = pins_i.latch;
    // Hardware gate opens on rise, closes on fall
    if (hw_rise) begin
      next_st.hw_open = 1'b1;
    end else if (!pins_i.hardware_gate && st.hw_prev) begin
      next_st.hw_open = 1'b0;
    end
    // Reopening after an automatic closure
    if (st.auto_closed) begin
      if (cfg_i.dir != gcnt_pkg::DIR_NONE) begin
        // Main direction: only a gate rising edge restarts, from the load value
        if ((cfg_i.hw_enable && hw_rise && cfg_i.software_gate_bit) ||
            (!cfg_i.hw_enable && sw_rise)) begin
          next_st.auto_closed = 1'b0;
          next_st.count = cfg_i.load_value;
        end
      end else if (sw_rise || (cfg_i.hw_enable && hw_rise)) begin
        next_st.auto_closed = 1'b0;
        if (!cfg_i.stop_fn) begin
          next_st.count = cfg_i.load_value;
        end
      end
    end else if (!cfg_i.stop_fn) begin
      // Cancel function: restart from load value on gate reopen
      // With the hardware gate in use only its edge restarts; a software edge continues
      if (cfg_i.hw_enable ? (hw_rise && cfg_i.software_gate_bit)
                          : sw_rise) begin
        next_st.count = cfg_i.load_value;
      end
    end
    // Clear first, so a flag set by a pulse in the same cycle survives the clear
    if (status_clear_request_i) begin
      next_st.ovf = 1'b0;
      next_st.unf = 1'b0;
    end
    // Counting, only while the internal gate is open; stop function keeps the value
    if (igate && up_pulse) begin
      if ((cfg_i.mode != gcnt_pkg::MODE_CONT) && (cfg_i.dir == gcnt_pkg::DIR_UP) &&
          (st.count == cfg_i.end_value - gcnt_pkg::ONE)) begin
        next_st.count = cfg_i.load_value;
        if (cfg_i.mode == gcnt_pkg::MODE_ONCE) begin
          next_st.auto_closed = 1'b1;
        end
      end else if (st.count == gcnt_pkg::COUNT_UPPER) begin
        next_st.count = gcnt_pkg::COUNT_LOWER;
        next_st.ovf = 1'b1;
        if ((cfg_i.mode == gcnt_pkg::MODE_ONCE) && (cfg_i.dir == gcnt_pkg::DIR_NONE)) begin
          next_st.auto_closed = 1'b1;
        end
      end else begin
        next_st.count = st.count + gcnt_pkg::ONE;
      end
    end else if (igate && dn_pulse) begin
      if ((cfg_i.mode != gcnt_pkg::MODE_CONT) && (cfg_i.dir == gcnt_pkg::DIR_DOWN) &&
          (st.count == cfg_i.end_value + gcnt_pkg::ONE)) begin
        next_st.count = cfg_i.load_value;
        if (cfg_i.mode == gcnt_pkg::MODE_ONCE) begin
          next_st.auto_closed = 1'b1;
        end
      end else if (st.count == gcnt_pkg::COUNT_LOWER) begin
        next_st.count = gcnt_pkg::COUNT_UPPER;
        next_st.unf = 1'b1;
        if ((cfg_i.mode == gcnt_pkg::MODE_ONCE) && (cfg_i.dir == gcnt_pkg::DIR_NONE)) begin
          next_st.auto_closed = 1'b1;
        end
      end else begin
        next_st.count = st.count - gcnt_pkg::ONE;
      end
    end
    // Latch on a rising edge of the latch pin
    if (pins_i.latch && !st.latch_prev) begin
      next_st.latch_value = st.count;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Count starts at the reset load value of zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops, except the gate term
  always_comb begin
    stat_o.count = st.count;
    stat_o.latch_value = st.latch_value;
    stat_o.overflow_flag = st.ovf;
    stat_o.underflow_flag = st.unf;
    stat_o.internal_gate = igate;
  end

endmodule // gcnt_core
`default_nettype wire

// ### src/gcnt_top.sv
// Top: Avalon-MM register slave around the gated up/down counter core
//
// What this block does
// - Continuous: overflow wraps to lower limit.
// - Continuous: underflow wraps to upper limit.
// - Sticky overflow/underflow flags, cleared by request.
// - Once, no direction: wrap, close gate, flag.
// - Reopen: stop resumes, cancel loads value.
// - Once up: at end-1 reload, close gate.
// - Once down: at end+1 reload, close gate.
// - Main direction restart: gate rising edge, load.
// - Periodic, no direction: wrap, keep counting.
// - Periodic up: at end-1 reload, continue.
// - Periodic down: at end+1 reload, continue.
// - Internal gate combines hardware and software gate.
// - Hardware gate opens rising, closes falling.
// - Cancel function: reopen restarts at load.
// - Stop function: reopen resumes last count.
// - Hardware edge restarts, software edge continues.
// - Latch rising edge captures present count.
`timescale 1ns/1ps
`default_nettype none
module gcnt_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Encoder and digital inputs
  input wire logic count_up_i,
  input wire logic count_down_i,
  input wire logic hardware_gate_i,
  input wire logic latch_i
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] control; // Control word
    logic [31:0] load_value; // Load value
    logic [31:0] end_value; // End value
    logic [31:0] rdata; // Read data register
    logic ack; // Answer phase: waitrequest drops
    logic clr; // One-cycle status clear request
  } regs_t;

  regs_t r;
  regs_t next_r;

  // Core connections
  gcnt_pkg::cfg_t cfg;
  gcnt_pkg::pins_t pins;
  gcnt_pkg::core_status_t cst;
  logic [31:0] wmask; // Byte-enable mask
  logic [31:0] rmux; // Read multiplexer

  // ----------------------------------------------------------------
  // Core
  // ----------------------------------------------------------------
  gcnt_core core (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .cfg_i(cfg),
    .status_clear_request_i(r.clr),
    .pins_i(pins),
    .stat_o(cst)
  );

  // Configuration fields from the control word
  always_comb begin
    cfg.load_value = r.load_value;
    cfg.end_value = r.end_value;
    cfg.mode = r.control[gcnt_pkg::CTL_MODE_LSB +: 2];
    cfg.dir = r.control[gcnt_pkg::CTL_DIR_LSB +: 2];
    cfg.hw_enable = r.control[gcnt_pkg::CTL_HWEN_BIT];
    cfg.stop_fn = r.control[gcnt_pkg::CTL_STOPFN_BIT];
    cfg.software_gate_bit = r.control[gcnt_pkg::CTL_SWGATE_BIT];
    pins.count_up = count_up_i;
    pins.count_down = count_down_i;
    pins.hardware_gate = hardware_gate_i;
    pins.latch = latch_i;
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Every access takes two cycles: request seen, then answer with waitrequest low.
  // Unmapped reads return zero, unmapped writes are dropped.
  always_comb begin
    next_r = r;
    next_r.clr = 1'b0;
    next_r.ack = 1'b0;
    wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    case (avs_address_i)
      gcnt_pkg::OFS_CONTROL: rmux = r.control;
      gcnt_pkg::OFS_LOAD: rmux = r.load_value;
      gcnt_pkg::OFS_END: rmux = r.end_value;
      gcnt_pkg::OFS_COUNT: rmux = cst.count;
      gcnt_pkg::OFS_LATCH: rmux = cst.latch_value;
      gcnt_pkg::OFS_STATUS: begin
        rmux = 32'h0000_0000;
        rmux[gcnt_pkg::STS_OVF_BIT] = cst.overflow_flag;
        rmux[gcnt_pkg::STS_UNF_BIT] = cst.underflow_flag;
        rmux[gcnt_pkg::STS_IGATE_BIT] = cst.internal_gate;
      end
      default: rmux = 32'h0000_0000;
    endcase
    if ((avs_read_i || avs_write_i) && !r.ack) begin
      next_r.ack = 1'b1;
      next_r.rdata = rmux;
    end
    // Write takes effect at the edge where waitrequest is low
    if (avs_write_i && r.ack) begin
      case (avs_address_i)
        gcnt_pkg::OFS_CONTROL:
          next_r.control = (r.control & ~wmask) | (avs_writedata_i & wmask);
        gcnt_pkg::OFS_LOAD:
          next_r.load_value = (r.load_value & ~wmask) | (avs_writedata_i & wmask);
        gcnt_pkg::OFS_END:
          next_r.end_value = (r.end_value & ~wmask) | (avs_writedata_i & wmask);
        gcnt_pkg::OFS_STATUS: begin
          next_r.clr = avs_writedata_i[gcnt_pkg::STS_CLR_BIT] &&
                       avs_byteenable_i[0];
        end
        default: begin
          next_r.clr = 1'b0;
        end
      endcase
    end
  end

  // Register stage
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r.control <= gcnt_pkg::CONTROL_RST;
      r.load_value <= gcnt_pkg::LOAD_RST;
      r.end_value <= gcnt_pkg::END_RST;
      r.rdata <= 32'h0000_0000;
      r.ack <= 1'b0;
      r.clr <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Handshake output is combinational; read data from flip-flops
  assign avs_waitrequest_o = !r.ack;
  assign avs_readdata_o = r.rdata;

endmodule // gcnt_top
`default_nettype wire

// ### sim/gcnt_enc_model.sv
// Encoder model: count pulse bursts, hardware gate pin and latch pin
`timescale 1ns/1ps
`default_nettype none
module gcnt_enc_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Bench commands
  input wire logic go_i,
  input wire logic [7:0] steps_i,
  input wire logic down_i,
  input wire logic slow_i,
  input wire logic gate_i,
  input wire logic latch_i,
  // Pins toward the counter
  output logic count_up_o,
  output logic count_down_o,
  output logic hardware_gate_o,
  output logic latch_o,
  output logic busy_o
);
  // ----------------------------------------------------------------
  // Pulse burst state
  // ----------------------------------------------------------------
  logic [7:0] left; // Pulses still to send
  logic gap; // Toggles so slow bursts leave a blank cycle
  logic fire; // A pulse stands in this cycle
  assign fire = (left != 8'h00) && (!slow_i || gap);
  assign count_up_o = fire && !down_i;
  assign count_down_o = fire && down_i;
  assign busy_o = (left != 8'h00);
  // One pulse per cycle, or every other cycle when slow
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      left <= 8'h00;
      gap <= 1'b0;
      hardware_gate_o <= 1'b0;
      latch_o <= 1'b0;
    end else begin
      gap <= ~gap;
      if (go_i) begin
        left <= steps_i;
      end else if (fire) begin
        left <= left - 8'h01;
      end
      // Gate pin edges open and close the hardware gate
      hardware_gate_o <= gate_i;
      latch_o <= latch_i;
    end
  end
endmodule // gcnt_enc_model
`default_nettype wire

// ### sim/gcnt_chk.sv
// Checker: bus handshake and register read relations of the counter top
`timescale 1ns/1ps
`default_nettype none
module gcnt_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Bus
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Pins
  input wire logic count_up_i,
  input wire logic count_down_i,
  input wire logic hardware_gate_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Helper logic: quiet time since anything could move the count
  // ----------------------------------------------------------------
  logic [2:0] since; // Cycles since a pulse, gate change or write
  logic [2:0] since_wr; // Cycles since a write
  logic gate_q; // Previous gate pin level
  logic cnt_ok; // Last count read is a valid base
  logic sts_ok; // Last status read is a valid base
  logic [31:0] last_cnt;
  logic [1:0] last_sts;
  logic done; // Read answered at this edge
  logic ev;
  assign done = avs_read_i && !avs_waitrequest_o;
  assign ev = count_up_i || count_down_i || avs_write_i || (hardware_gate_i != gate_q);
  // Bases are taken only after four quiet cycles, so late reloads cannot fool us
  always_ff @(posedge mclk_i) begin
    gate_q <= hardware_gate_i;
    if (rst_i) begin
      since <= 3'h0;
      since_wr <= 3'h0;
      cnt_ok <= 1'b0;
      sts_ok <= 1'b0;
    end else begin
      since <= ev ? 3'h0 : (since == 3'h7 ? since : since + 3'h1);
      since_wr <= avs_write_i ? 3'h0 : (since_wr == 3'h7 ? since_wr : since_wr + 3'h1);
      if (done && avs_address_i == gcnt_pkg::OFS_COUNT) begin
        cnt_ok <= (since > 3'h3) && !ev;
        last_cnt <= avs_readdata_o;
      end else if (ev) begin
        cnt_ok <= 1'b0;
      end
      if (done && avs_address_i == gcnt_pkg::OFS_STATUS) begin
        sts_ok <= (since_wr > 3'h3) && !avs_write_i;
        last_sts <= avs_readdata_o[1:0];
      end else if (avs_write_i) begin
        sts_ok <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("waitrequest did not drop one cycle after a request");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    avs_waitrequest_o) else $error("answer without a request");
  a_data_hold: assert property (!(avs_read_i || avs_write_i) |=> $stable(avs_readdata_o))
    else $error("read data moved without an access");
  a_unmapped_zero: assert property (done && avs_address_i > gcnt_pkg::OFS_STATUS |->
    avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_ctl_upper: assert property (done && avs_address_i == gcnt_pkg::OFS_CONTROL |->
    avs_readdata_o[31:7] == 25'h0000000) else $error("control upper bits not zero");
  a_count_steady: assert property (done && avs_address_i == gcnt_pkg::OFS_COUNT && cnt_ok |->
    avs_readdata_o == last_cnt) else $error("count moved without a pulse");
  a_flags_sticky: assert property (done && avs_address_i == gcnt_pkg::OFS_STATUS && sts_ok |->
    (avs_readdata_o[1:0] & last_sts) == last_sts) else $error("flag dropped without clear");
  // Main scenarios reached
  c_count_read: cover property (done && avs_address_i == gcnt_pkg::OFS_COUNT && cnt_ok);
  c_flag_seen: cover property (done && avs_address_i == gcnt_pkg::OFS_STATUS && avs_readdata_o[0]);
  c_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule // gcnt_chk
bind gcnt_top gcnt_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .count_up_i(count_up_i),
  .count_down_i(count_down_i), .hardware_gate_i(hardware_gate_i));
`default_nettype wire

// ### sim/gated_updown_counter_modes_test.sv
// Testbench: register-level scenarios for the gated up/down counter
`timescale 1ns/1ps
`default_nettype none
module gated_updown_counter_modes_test;
  // ----------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic count_up_i, count_down_i, hardware_gate_i, latch_i, busy;
  logic go = 1'b0, dn = 1'b0, slow = 1'b0, gate = 1'b0, lat = 1'b0;
  logic [7:0] steps = 8'h00;
  int fail_count = 0, total_checks = 0, cyc = 0;
  localparam logic [4:0] AC = gcnt_pkg::OFS_CONTROL, AL = gcnt_pkg::OFS_LOAD;
  localparam logic [4:0] AE = gcnt_pkg::OFS_END, AN = gcnt_pkg::OFS_COUNT;
  localparam logic [4:0] AT = gcnt_pkg::OFS_LATCH, AS = gcnt_pkg::OFS_STATUS;
  // Control words: software gate, stop function, hardware gate enable, modes, directions
  localparam logic [31:0] SW = 32'h40, STP = 32'h20, HWE = 32'h10, ONCE = 32'h1;
  localparam logic [31:0] PER = 32'h3, UP = 32'h4, DN = 32'hC;
  always #2.5 mclk_i = ~mclk_i;
  // ----------------------------------------------------------------
  // Design and encoder model
  // ----------------------------------------------------------------
  gcnt_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .count_up_i(count_up_i),
    .count_down_i(count_down_i), .hardware_gate_i(hardware_gate_i), .latch_i(latch_i));
  gcnt_enc_model enc (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .steps_i(steps),
    .down_i(dn), .slow_i(slow), .gate_i(gate), .latch_i(lat), .count_up_o(count_up_i),
    .count_down_o(count_down_i), .hardware_gate_o(hardware_gate_i), .latch_o(latch_i),
    .busy_o(busy));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Held until waitrequest is seen low; an idle cycle keeps drivers single per step
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    @(posedge mclk_i);
    while (avs_waitrequest_o) @(posedge mclk_i);
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] v;
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    @(posedge mclk_i);
    while (avs_waitrequest_o) @(posedge mclk_i);
    v = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
    total_checks++;
    if (v !== e) begin
      fail_count++;
      $display("BAD reg %h expected %h seen %h", a, e, v);
    end
  endtask
  // Burst of n pulses; waits on the model's busy flag
  task automatic pulse(input logic [7:0] n, input logic down, input logic sl);
    steps <= n;
    dn <= down;
    slow <= sl;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    @(posedge mclk_i);
    while (busy) @(posedge mclk_i);
    @(posedge mclk_i);
  endtask
  task automatic pin(input logic g, input logic l);
    gate <= g;
    lat <= l;
    repeat (4) @(posedge mclk_i);
  endtask
  // Cuts a hang short
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk(AC, 32'h0);
    chk(AS, 32'h0);
    chk(5'h18, 32'h0);
    wr(AN, 32'h1234);
    chk(AN, 32'h0);
    // Continuous mode wraps at both limits
    wr(AL, 32'h7FFF_FFFD);
    wr(AC, SW);
    chk(AN, 32'h7FFF_FFFD);
    pulse(8'h03, 1'b0, 1'b1);
    chk(AN, 32'h8000_0000);
    chk(AS, 32'h5);
    chk(AS, 32'h5);
    wr(AS, 32'h1);
    chk(AS, 32'h4);
    pulse(8'h01, 1'b1, 1'b0);
    chk(AN, 32'h7FFF_FFFF);
    chk(AS, 32'h6);
    // Closed gate ignores pulses; stop function resumes
    wr(AC, 32'h0);
    pulse(8'h04, 1'b0, 1'b0);
    chk(AN, 32'h7FFF_FFFF);
    wr(AC, STP | SW);
    chk(AN, 32'h7FFF_FFFF);
    pulse(8'h02, 1'b1, 1'b0);
    chk(AN, 32'h7FFF_FFFD);
    // Count once without direction: wrap and close
    wr(AS, 32'h1);
    wr(AC, 32'h0);
    wr(AL, 32'h7FFF_FFFE);
    wr(AC, ONCE | SW);
    pulse(8'h03, 1'b0, 1'b0);
    chk(AN, 32'h8000_0000);
    chk(AS, 32'h1);
    wr(AC, ONCE | STP);
    wr(AC, ONCE | STP | SW);
    chk(AN, 32'h8000_0000);
    pulse(8'h02, 1'b1, 1'b0);
    chk(AN, 32'h7FFF_FFFF);
    chk(AS, 32'h3);
    wr(AC, ONCE);
    wr(AC, ONCE | SW);
    chk(AN, 32'h7FFF_FFFE);
    // Count once up: reload at end minus one, restart by a gate pin edge
    wr(AS, 32'h1);
    wr(AC, ONCE | UP);
    wr(AL, 32'h5);
    wr(AE, 32'h8);
    wr(AC, ONCE | UP | SW);
    pulse(8'h04, 1'b0, 1'b1);
    chk(AN, 32'h5);
    chk(AS, 32'h0);
    wr(AC, ONCE | UP | SW | HWE);
    pin(1'b1, 1'b0);
    pulse(8'h01, 1'b0, 1'b0);
    chk(AN, 32'h6);
    pin(1'b0, 1'b0);
    // Count once down: reload at end plus one
    wr(AC, ONCE | DN);
    wr(AE, 32'h2);
    wr(AC, ONCE | DN | SW);
    pulse(8'h04, 1'b1, 1'b0);
    chk(AN, 32'h5);
    chk(AS, 32'h0);
    // Periodic up and down with reloads
    wr(AC, PER | UP);
    wr(AL, 32'h0);
    wr(AE, 32'h3);
    wr(AC, PER | UP | SW);
    pulse(8'h04, 1'b0, 1'b0);
    chk(AN, 32'h1);
    chk(AS, 32'h4);
    wr(AC, PER | DN);
    wr(AL, 32'h7FFF_FFFF);
    wr(AE, 32'h7FFF_FFFD);
    wr(AC, PER | DN | SW);
    pulse(8'h02, 1'b1, 1'b0);
    chk(AN, 32'h7FFF_FFFF);
    pulse(8'h01, 1'b0, 1'b0);
    chk(AN, 32'h8000_0000);
    chk(AS, 32'h5);
    // Periodic without direction keeps counting past a limit
    wr(AS, 32'h1);
    wr(AC, PER);
    wr(AL, 32'h8000_0001);
    wr(AC, PER | SW);
    pulse(8'h03, 1'b1, 1'b1);
    chk(AN, 32'h7FFF_FFFE);
    chk(AS, 32'h6);
    // Hardware gate with cancel function
    wr(AC, 32'h0);
    wr(AL, 32'hA);
    wr(AC, HWE | SW);
    pulse(8'h02, 1'b0, 1'b0);
    chk(AN, 32'h7FFF_FFFE);
    pin(1'b1, 1'b0);
    chk(AN, 32'hA);
    pulse(8'h03, 1'b0, 1'b0);
    pin(1'b0, 1'b0);
    pulse(8'h02, 1'b0, 1'b0);
    chk(AN, 32'hD);
    pin(1'b1, 1'b0);
    chk(AN, 32'hA);
    pulse(8'h01, 1'b0, 1'b0);
    wr(AC, HWE);
    wr(AC, HWE | SW);
    chk(AN, 32'hB);
    // Latch pin captures the count
    pin(1'b1, 1'b1);
    chk(AT, 32'hB);
    chk(AN, 32'hB);
    chk(AN, 32'hB);
    // Reset in mid-run returns count, latch and flags to zero
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk(AN, 32'h0);
    chk(AT, 32'h0);
    chk(AS, 32'h0);
    print_verdict();
  end
endmodule // gated_updown_counter_modes_test
`default_nettype wire
